// [verilog/edfc_defs.vh]
// edfc_defs.vh: register offsets, field positions and reset values for the
// descriptor and receive-filter configuration block.
// assumes inclusion by bare name from the design file; definitions only.
`ifndef EDFC_DEFS_VH
`define EDFC_DEFS_VH

// register byte offsets on the apb window
`define EDFC_OFF_CTRL1 12'h000
`define EDFC_OFF_CTRL2 12'h004
`define EDFC_OFF_TXST 12'h008
`define EDFC_OFF_RXST 12'h00c
`define EDFC_OFF_HT0 12'h010
`define EDFC_OFF_HT1 12'h014
`define EDFC_OFF_PMM0 12'h018
`define EDFC_OFF_PMM1 12'h01c
`define EDFC_OFF_PATTERN_CHECKSUM_VALUE 12'h020
`define EDFC_OFF_PMO 12'h024
`define EDFC_OFF_RXFC 12'h028

// control register 1 fields
`define EDFC_RECEIVE_ENABLE_BIT_BIT 8

// control register 2 fields
`define EDFC_BUFSZ_LSB 4
`define EDFC_BUFSZ_MSB 10
`define EDFC_BUFSZ_SHIFT 4

// receive filter config fields
`define EDFC_HASH_FILTER_ENABLE_BIT 15
`define EDFC_MAGIC_PACKET_FILTER_ENABLE_BIT 14
`define EDFC_PATTERN_MATCH_INVERT_BIT 12
`define EDFC_PATTERN_MATCH_SELECT_LSB 8
`define EDFC_PATTERN_MATCH_SELECT_MSB 11
`define EDFC_RXFC_MASK 32'h0000dfff

// reset values
`define EDFC_RST_WORD 32'h00000000

`endif

// [verilog/edfc_top.v]
// edfc_top.v: apb register slave holding receive buffer size, descriptor
// start pointers, hash table and pattern-match settings, plus the derived
// per-packet decisions used by the receive path.
// assumes one 10 mhz clock, synchronous reset and a correct apb master.
//
// Local design decisions: the register offsets and the APB register port.
`default_nettype none
`include "edfc_defs.vh"

module edfc_top (
	// clock and reset
	input wire clock_in,
	input wire srst_in,
	// apb slave
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [11:0] paddr_in,
	input wire [31:0] pwdata_in,
	input wire [3:0] pstrb_in,
	output reg [31:0] prdata_out,
	output reg pready_out,
	output reg pslverr_out,
	// descriptor engine: pointer updates after transmit and receive
	input wire tx_done_in,
	input wire [31:0] tx_last_desc_in,
	input wire rx_done_in,
	input wire [31:0] rx_last_desc_in,
	// receive path per-packet inputs
	input wire pkt_valid_in,
	input wire hash_hit_in,
	input wire [15:0] pkt_checksum_in,
	input wire [3:0] pkt_class_in,
	// configuration seen by the receive and descriptor engines
	output reg receive_enable_bit_out,
	output reg [10:0] rx_buffer_bytes_out,
	output reg [31:0] tx_descriptor_base_out,
	output reg [31:0] rx_descriptor_base_out,
	output reg [63:0] hash_filter_table_out,
	output reg [63:0] pattern_byte_mask_out,
	output reg [15:0] pattern_start_offset_out,
	// per-packet decisions, one cycle after pkt_valid_in
	output reg pkt_store_out,
	output reg pkt_hash_pass_out,
	output reg pattern_match_out
);

	// stored register fields
	reg receive_enable_bit; // receive enable
	reg [6:0] rx_buffer_size_units; // buffer size in 16-byte units
	reg [29:0] tx_descriptor_base; // pointer bits 31:2
	reg [29:0] rx_descriptor_base;
	reg [31:0] hash_table_low;
	reg [31:0] hash_table_high;
	reg [31:0] pattern_mask_low;
	reg [31:0] pattern_mask_high;
	reg [15:0] pattern_checksum_value;
	reg [15:0] pattern_start_offset;
	reg hash_filter_enable;
	reg magic_packet_filter_enable;
	reg pattern_match_invert;
	reg [3:0] pattern_match_select;
	reg [11:0] filter_misc; // remaining filter-config bits, stored only

	// bus decode
	wire access_phase; // apb access cycle
	wire wr_en;
	reg [31:0] read_word;
	reg addr_hit;
	reg [31:0] byte_mask;
	wire [31:0] merged_word; // addressed word with the strobed bytes replaced
	integer i;

	// merge bytes under the strobes
	function [31:0] edfc_merge;
		input [31:0] old_word;
		input [31:0] new_word;
		input [31:0] mask;
		begin
			edfc_merge = (old_word & ~mask) | (new_word & mask);
		end
	endfunction

	// read_word already shows the addressed register with its zero fields,
	// so one merge serves the buffer-size, pointer, checksum and offset registers and no field is cut by a shift
	assign merged_word = edfc_merge(read_word, pwdata_in, byte_mask);
	assign access_phase = psel_in & penable_in;
	assign wr_en = access_phase & pwrite_in & ~pready_out;

	// byte strobes expanded to a bit mask
	always @* begin
		for (i = 0; i < 4; i = i + 1) begin
			byte_mask[i*8 +: 8] = {8{pstrb_in[i]}};
		end
	end

	// read mux; unimplemented bits are zero through the concatenations
	always @* begin
		addr_hit = 1'b1;
		read_word = `EDFC_RST_WORD;
		case (paddr_in)
			`EDFC_OFF_CTRL1: begin
				read_word[`EDFC_RECEIVE_ENABLE_BIT_BIT] = receive_enable_bit;
			end
			`EDFC_OFF_CTRL2: begin
				read_word = {21'h000000, rx_buffer_size_units, 4'h0};
			end
			`EDFC_OFF_TXST: begin
				read_word = {tx_descriptor_base, 2'h0};
			end
			`EDFC_OFF_RXST: begin
				read_word = {rx_descriptor_base, 2'h0};
			end
			`EDFC_OFF_HT0: read_word = hash_table_low;
			`EDFC_OFF_HT1: read_word = hash_table_high;
			`EDFC_OFF_PMM0: read_word = pattern_mask_low;
			`EDFC_OFF_PMM1: read_word = pattern_mask_high;
			`EDFC_OFF_PATTERN_CHECKSUM_VALUE: begin
				read_word = {16'h0000, pattern_checksum_value};
			end
			`EDFC_OFF_PMO: begin
				read_word = {16'h0000, pattern_start_offset};
			end
			`EDFC_OFF_RXFC: begin
				read_word = {16'h0000, hash_filter_enable, magic_packet_filter_enable,
					1'b0, pattern_match_invert, pattern_match_select,
					filter_misc[7:0]};
			end
			default: addr_hit = 1'b0; // unmapped: error, zero data
		endcase
	end

	// apb handshake: one wait state, answer on the second access cycle
	always @(posedge clock_in) begin
		if (srst_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= `EDFC_RST_WORD;
		end else if (access_phase & ~pready_out) begin
			pready_out <= 1'b1;
			pslverr_out <= ~addr_hit;
			prdata_out <= pwrite_in ? `EDFC_RST_WORD : read_word;
		end else begin
			// pready drops after one cycle so back-to-back requests re-handshake
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= `EDFC_RST_WORD;
		end
	end

	// register writes and hardware pointer updates
	always @(posedge clock_in) begin
		if (srst_in) begin
			receive_enable_bit <= 1'b0;
			rx_buffer_size_units <= 7'h00;
			tx_descriptor_base <= 30'h00000000;
			rx_descriptor_base <= 30'h00000000;
			hash_table_low <= `EDFC_RST_WORD;
			hash_table_high <= `EDFC_RST_WORD;
			pattern_mask_low <= `EDFC_RST_WORD;
			pattern_mask_high <= `EDFC_RST_WORD;
			pattern_checksum_value <= 16'h0000;
			pattern_start_offset <= 16'h0000;
			hash_filter_enable <= 1'b0;
			magic_packet_filter_enable <= 1'b0;
			pattern_match_invert <= 1'b0;
			pattern_match_select <= 4'h0;
			filter_misc <= 12'h000;
		end else begin
			// hardware pointer reload; a software write in the same cycle wins
			// since software is barred from writing while traffic runs
			if (tx_done_in) begin
				tx_descriptor_base <= tx_last_desc_in[31:2];
			end
			if (rx_done_in) begin
				rx_descriptor_base <= rx_last_desc_in[31:2];
			end
			if (wr_en) begin
				case (paddr_in)
					`EDFC_OFF_CTRL1: begin
						if (pstrb_in[1]) begin
							receive_enable_bit <= pwdata_in[`EDFC_RECEIVE_ENABLE_BIT_BIT];
						end
					end
					`EDFC_OFF_CTRL2: begin
						// the guard against changes while receiving is software's job
						rx_buffer_size_units <=
							merged_word[`EDFC_BUFSZ_MSB:`EDFC_BUFSZ_LSB];
					end
					`EDFC_OFF_TXST: begin
						tx_descriptor_base <= merged_word[31:2];
					end
					`EDFC_OFF_RXST: begin
						rx_descriptor_base <= merged_word[31:2];
					end
					`EDFC_OFF_HT0: begin
						hash_table_low <= edfc_merge(hash_table_low, pwdata_in, byte_mask);
					end
					`EDFC_OFF_HT1: begin
						hash_table_high <= edfc_merge(hash_table_high, pwdata_in, byte_mask);
					end
					`EDFC_OFF_PMM0: begin
						pattern_mask_low <= edfc_merge(pattern_mask_low, pwdata_in,
							byte_mask);
					end
					`EDFC_OFF_PMM1: begin
						pattern_mask_high <= edfc_merge(pattern_mask_high, pwdata_in,
							byte_mask);
					end
					`EDFC_OFF_PATTERN_CHECKSUM_VALUE: begin
						pattern_checksum_value <= merged_word[15:0];
					end
					`EDFC_OFF_PMO: begin
						pattern_start_offset <= merged_word[15:0];
					end
					`EDFC_OFF_RXFC: begin
						if (pstrb_in[1]) begin
							hash_filter_enable <= pwdata_in[`EDFC_HASH_FILTER_ENABLE_BIT];
							magic_packet_filter_enable <= pwdata_in[`EDFC_MAGIC_PACKET_FILTER_ENABLE_BIT];
							pattern_match_invert <= pwdata_in[`EDFC_PATTERN_MATCH_INVERT_BIT];
							pattern_match_select <=
								pwdata_in[`EDFC_PATTERN_MATCH_SELECT_MSB:`EDFC_PATTERN_MATCH_SELECT_LSB];
						end
						if (pstrb_in[0]) begin
							filter_misc[7:0] <= pwdata_in[7:0];
						end
					end
					default: begin
						// unmapped write is dropped
					end
				endcase
			end
		end
	end

	// checksum comparison, inverted when asked
	wire cs_equal;
	wire cs_ok;
	assign cs_equal = (pkt_checksum_in == pattern_checksum_value);
	assign cs_ok = pattern_match_invert ^ cs_equal;

	// packet qualifier per pattern mode; modes 2 to 9 each look at one class or the hash hit
	reg class_hit;
	always @* begin
		case (pattern_match_select)
			4'h1: class_hit = 1'b1; // checksum alone
			4'h2, 4'h3: class_hit = pkt_class_in[0]; // station address
			4'h4, 4'h5: class_hit = pkt_class_in[1]; // unicast
			4'h6, 4'h7: class_hit = pkt_class_in[2]; // broadcast
			4'h8: class_hit = hash_hit_in; // hash hit, whatever the hash enable
			4'h9: class_hit = pkt_class_in[3]; // magic packet
			default: class_hit = 1'b0; // mode zero and unused codes never match
		endcase
	end

	// packet decisions and configuration outputs, all registered
	always @(posedge clock_in) begin
		if (srst_in) begin
			pkt_store_out <= 1'b0;
			pkt_hash_pass_out <= 1'b0;
			pattern_match_out <= 1'b0;
			receive_enable_bit_out <= 1'b0;
			rx_buffer_bytes_out <= 11'h000;
			tx_descriptor_base_out <= `EDFC_RST_WORD;
			rx_descriptor_base_out <= `EDFC_RST_WORD;
			hash_filter_table_out <= 64'h0000000000000000;
			pattern_byte_mask_out <= 64'h0000000000000000;
			pattern_start_offset_out <= 16'h0000;
		end else begin
			receive_enable_bit_out <= receive_enable_bit;
			rx_buffer_bytes_out <= {rx_buffer_size_units, 4'h0};
			tx_descriptor_base_out <= {tx_descriptor_base, 2'h0};
			rx_descriptor_base_out <= {rx_descriptor_base, 2'h0};
			hash_filter_table_out <= {hash_table_high, hash_table_low};
			pattern_byte_mask_out <= {pattern_mask_high, pattern_mask_low};
			pattern_start_offset_out <= pattern_start_offset;
			// nothing is stored unless reception is on
			pkt_store_out <= pkt_valid_in & receive_enable_bit;
			// hash stage passes everything when disabled
			pkt_hash_pass_out <= pkt_valid_in & receive_enable_bit
				& (~hash_filter_enable | hash_hit_in);
			// mode zero and codes 10 to 15 never match; mode 1 takes the checksum alone, modes 2 to 9 qualify with packet class or hash hit
			pattern_match_out <= pkt_valid_in & cs_ok & class_hit;
		end
	end

endmodule
`default_nettype wire

// [tb/edfc_desc_model.sv]
// descriptor engine model: walks a list, then reports the last descriptor
// assumes one clock and a synchronous active-high reset
`default_nettype none
module edfc_desc_model (
	// clock and reset
	input wire logic clock_in,
	input wire logic srst_in,
	// request from the bench
	input wire logic go_in,
	input wire logic rx_in,
	input wire logic [31:0] last_in,
	input wire logic [3:0] wait_in,
	// towards the block
	output logic tx_done_out,
	output logic rx_done_out,
	output logic [31:0] last_desc_out,
	output logic busy_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt; // cycles left in the walk
	logic dir; // walk is on the receive side
	logic [31:0] last; // descriptor that ends the walk
	// one done pulse per walk; address valid only with it
	always @(posedge clock_in) begin
		tx_done_out <= 1'b0;
		rx_done_out <= 1'b0;
		// stale address flips so it never passes for a valid one
		last_desc_out <= ~last_desc_out;
		if (srst_in) begin
			busy_out <= 1'b0;
			cnt <= 4'h0;
			last_desc_out <= 32'h0;
		end else if (go_in && !busy_out) begin
			busy_out <= 1'b1;
			cnt <= wait_in;
			dir <= rx_in;
			last <= last_in;
		end else if (busy_out && cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end else if (busy_out) begin
			// report the end of the walk
			busy_out <= 1'b0;
			tx_done_out <= !dir;
			rx_done_out <= dir;
			last_desc_out <= last;
		end
	end
endmodule
`default_nettype wire

// [tb/edfc_top_checker.sv]
// checker for edfc_top: apb timing, read-zero fields, pointer reload
// assumes it is bound onto edfc_top, one clock, sync reset high
`default_nettype none
module edfc_top_checker (
	// clock and reset
	input wire logic clock_in,
	input wire logic srst_in,
	// apb
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	// engine and receive side
	input wire logic tx_done_in,
	input wire logic [31:0] tx_last_desc_in,
	input wire logic pkt_valid_in,
	input wire logic receive_enable_bit_out,
	input wire logic pkt_store_out,
	input wire logic [31:0] tx_descriptor_base_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock_in); endclocking
	default disable iff (srst_in);
	// read completing now
	wire logic rd_done = pready_out && !pwrite_in;
	// lone reload with no software write beside it
	sequence reload_s;
		tx_done_in && !(psel_in && penable_in && pwrite_in) ##1 !tx_done_in;
	endsequence
	ready_wait_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
		else $error("late pready");
	ready_pulse_a: assert property (pready_out |=> !pready_out) else $error("long pready");
	err_ready_a: assert property (pslverr_out |-> pready_out) else $error("stray error");
	unmapped_err_a: assert property (pready_out && paddr_in >= 12'h02c |-> pslverr_out
		&& prdata_out == 32'h0) else $error("unmapped access");
	ctrl2_zero_a: assert property (rd_done && paddr_in == 12'h004 |->
		prdata_out[31:11] == 21'h0 && prdata_out[3:0] == 4'h0) else $error("ctrl2 bits");
	upper_zero_a: assert property (rd_done && paddr_in[11:3] == 9'h004 |->
		prdata_out[31:16] == 16'h0) else $error("upper half");
	base_align_a: assert property (tx_descriptor_base_out[1:0] == 2'h0)
		else $error("pointer low bits");
	store_gate_a: assert property (pkt_valid_in ##1 !receive_enable_bit_out |->
		!pkt_store_out) else $error("stored while off");
	tx_reload_a: assert property (reload_s |=> (tx_descriptor_base_out >> 2) ==
		($past(tx_last_desc_in, 2) >> 2)) else $error("pointer reload");
endmodule
bind edfc_top edfc_top_checker i_edfc_top_checker (.clock_in, .srst_in, .psel_in,
	.penable_in, .pwrite_in, .paddr_in, .prdata_out, .pready_out, .pslverr_out, .tx_done_in,
	.tx_last_desc_in, .pkt_valid_in, .receive_enable_bit_out, .pkt_store_out,
	.tx_descriptor_base_out);
`default_nettype wire

// [tb/edfc_top_test.sv]
// bench for edfc_top: registers, pointer reload, per-packet decisions
// assumes the engine model and checker files are compiled first
`default_nettype none
module edfc_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock_in = 0;
	logic srst_in = 1;
	logic psel_in = 0, penable_in = 0, pwrite_in = 0, pkt_valid_in = 0, hash_hit_in = 0;
	logic go_in = 0, rx_in = 0, er, pready_out, pslverr_out, tx_done_in, rx_done_in, busy_out;
	logic st, hp, pm; // packet decisions captured where settled
	logic [11:0] paddr_in = 0;
	logic [31:0] pwdata_in = 0, last_in = 0, rd, r, prdata_out, tx_last_desc_in;
	logic [15:0] pkt_checksum_in = 0, pattern_start_offset_out;
	logic [3:0] pkt_class_in = 0, wait_in = 0;
	logic receive_enable_bit_out, pkt_store_out, pkt_hash_pass_out, pattern_match_out;
	logic [31:0] tx_descriptor_base_out, rx_descriptor_base_out, regs [0:10];
	logic [10:0] rx_buffer_bytes_out;
	logic [63:0] hash_filter_table_out, pattern_byte_mask_out;
	int n_errors = 0, checks_done = 0, i, m;
	edfc_top i_edfc_top (.clock_in, .srst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
		.pwdata_in, .pstrb_in(4'hf), .prdata_out, .pready_out, .pslverr_out, .tx_done_in,
		.tx_last_desc_in, .rx_done_in, .rx_last_desc_in(tx_last_desc_in), .pkt_valid_in,
		.hash_hit_in, .pkt_checksum_in, .pkt_class_in, .receive_enable_bit_out,
		.rx_buffer_bytes_out, .tx_descriptor_base_out, .rx_descriptor_base_out,
		.hash_filter_table_out, .pattern_byte_mask_out, .pattern_start_offset_out,
		.pkt_store_out, .pkt_hash_pass_out, .pattern_match_out);
	edfc_desc_model i_edfc_desc_model (.clock_in, .srst_in, .go_in, .rx_in, .last_in,
		.wait_in, .tx_done_out(tx_done_in), .rx_done_out(rx_done_in),
		.last_desc_out(tx_last_desc_in), .busy_out);
	// 100 ns clock
	initial forever #50 clock_in = ~clock_in;
	task automatic close_out;
		if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic tmo;
		n_errors++;
		$display("mismatch at %0t: wait ran out", $time);
		close_out;
	endtask
	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// one apb transfer, entered just after an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel_in <= 1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clock_in);
		penable_in <= 1;
		for (k = 0; k < 9 && pready_out !== 1'b1; k++) @(posedge clock_in);
		if (k == 9) tmo;
		rd = prdata_out;
		er = pslverr_out;
		psel_in <= 0;
		penable_in <= 0;
		@(posedge clock_in);
	endtask
	// one packet; decisions read at the falling edge after the edge that takes it
	task automatic pkt;
		logic [31:0] v;
		v = $urandom;
		pkt_valid_in <= 1;
		hash_hit_in <= v[0];
		pkt_checksum_in <= v[1] ? regs[8][15:0] : v[31:16];
		pkt_class_in <= v[5:2];
		@(posedge clock_in);
		pkt_valid_in <= 0;
		// decisions launched at that edge are read mid-cycle, not in its time step
		@(negedge clock_in);
		st = pkt_store_out;
		hp = pkt_hash_pass_out;
		pm = pattern_match_out;
		@(posedge clock_in);
	endtask
	// writable bits of each word from 1 to 10
	function automatic logic [31:0] msk(input int x);
		case (x)
			1: return 32'h000007f0;
			2, 3: return 32'hfffffffc;
			8, 9: return 32'h0000ffff;
			10: return 32'h0000dfff;
			default: return 32'hffffffff;
		endcase
	endfunction
	// expected match per mode, with inversion
	function automatic logic pm_exp(input logic [3:0] md, input logic inv);
		logic c;
		c = inv ^ (pkt_checksum_in == regs[8][15:0]);
		case (md)
			0: return 1'b0;
			1: return c;
			2, 3: return c & pkt_class_in[0];
			4, 5: return c & pkt_class_in[1];
			6, 7: return c & pkt_class_in[2];
			8: return c & hash_hit_in;
			default: return c & pkt_class_in[3];
		endcase
	endfunction
	initial begin
		void'($urandom(32'hfbf0));
		repeat (6) @(posedge clock_in);
		srst_in <= 0;
		@(posedge clock_in);
		// reset values, then the unmapped word
		for (i = 0; i < 12; i++) begin
			apb(0, 12'(4 * i), 32'h0);
			cmp({er, rd}, {i == 11, 32'h0});
		end
		apb(1, 12'h030, 32'hffffffff);
		cmp(er, 1'b1);
		// all-ones corner first, random words next; receive stays off
		for (m = 0; m < 2; m++) begin
			for (i = 1; i < 11; i++) begin
				regs[i] = m ? $urandom : 32'hffffffff;
				apb(1, 12'(4 * i), regs[i]);
				regs[i] &= msk(i);
			end
			for (i = 1; i < 11; i++) begin
				apb(0, 12'(4 * i), 32'h0);
				cmp(rd, regs[i]);
			end
			cmp(rx_buffer_bytes_out, {regs[1][10:4], 4'h0});
			cmp(hash_filter_table_out, {regs[5], regs[4]});
			cmp(pattern_byte_mask_out, {regs[7], regs[6]});
			cmp(pattern_start_offset_out, regs[9][15:0]);
			cmp({tx_descriptor_base_out, rx_descriptor_base_out}, {regs[2], regs[3]});
		end
		// prompt then slow walk; no register traffic meanwhile
		for (m = 0; m < 2; m++) begin
			rx_in <= m[0];
			last_in <= $urandom;
			wait_in <= m ? 4'hf : 4'h0;
			go_in <= 1;
			@(posedge clock_in);
			go_in <= 0;
			@(posedge clock_in);
			for (i = 0; i < 40 && busy_out !== 1'b0; i++) @(posedge clock_in);
			if (i == 40) tmo;
			repeat (2) @(posedge clock_in);
			cmp(m ? rx_descriptor_base_out : tx_descriptor_base_out, last_in & 32'hfffffffc);
		end
		// receive off: nothing stored
		repeat (4) begin
			pkt;
			cmp(st, 1'b0);
		end
		// every pattern mode, filters set with receive off
		for (m = 0; m < 10; m++) begin
			r = $urandom;
			apb(1, 12'h000, 32'h0);
			apb(1, 12'h028, {16'h0, r[0], 2'h0, r[1], m[3:0], 8'h00});
			apb(1, 12'h000, 32'h100);
			repeat (4) begin
				pkt;
				cmp(pm, pm_exp(m[3:0], r[1]));
				cmp(st, 1'b1);
				if (r[0]) cmp(hp, hash_hit_in);
				else cmp(hp, 1'b1);
			end
		end
		close_out;
	end
endmodule
`default_nettype wire
